// ===== irap_pkg.sv
// Constants and carrier types of the two-wire register access port.
// Assumes one 10 MHz system clock and a synchronous active-high reset.
//
// What this block does
// [R1] Address byte, then pointer byte with top bit zero, then words high byte first.
// [R2] Register written only after the full low data byte has arrived.
// [R3] Pointer advances after every complete 16-bit word in a burst.
// [R4] Plain mode adds one per word, holding at the last register address.
// [R5] Host reads by writing pointer, then restart or stop-start with read bit.
// [R6] Unused addresses store nothing on write and read back as zero.
// [R7] Writes to read-only registers are discarded.
// [R8] Each further two bytes move the pointer and transfer the next register.
// [R9] Host ends reads with a NACK, writes with a stop; up to twenty words.
// [R10] Two advance modes, plain and contextual, chosen by ctx_mode_in; reset does not select one.
// [R11] Contextual DAC bursts start at the pointer the host writes, whether or not that port is DAC-configured.
// [R12] Contextual writes step to the next higher DAC-configured port.
// [R13] After the highest DAC port the pointer wraps to the lowest one.
// [R14] Contextual stepping only for DAC data writes and ADC data reads.
// [R15] Contextual ADC reads step upward to ADC ports and wrap likewise.
// [R16] Target address is 0111 plus three bits from two four-way straps.
// [R17] Works as target up to 400 kHz serial clock.
`default_nettype none

package irap_pkg;

	localparam int CLK_HZ = 10_000_000;
	localparam int SCL_MAX_HZ = 400_000;
	// System clocks per serial clock period at the fastest rate
	localparam int SCL_PERIOD_CYC = CLK_HZ / SCL_MAX_HZ;

	localparam logic [3:0] ADDR_FIXED = 4'h7;
	localparam logic [6:0] PTR_LAST = 7'h7f;
	localparam int NUM_PORTS = 20;
	localparam logic [6:0] DAC_BASE = 7'h60;
	localparam logic [6:0] ADC_BASE = 7'h40;

	// Strap connection codes
	localparam logic [1:0] STRAP_GND = 2'h0;
	localparam logic [1:0] STRAP_SDA = 2'h1;
	localparam logic [1:0] STRAP_SCL = 2'h2;
	localparam logic [1:0] STRAP_VDD = 2'h3;

	typedef enum logic [2:0] {
		IRAP_IDLE,
		IRAP_ADDR,
		IRAP_PTR,
		IRAP_WDATA,
		IRAP_RDATA,
		IRAP_ACK_OUT,
		IRAP_ACK_IN,
		IRAP_SKIP
	} irap_state_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [6:0] addr;
		logic [15:0] wdata;
	} irap_req_t;

endpackage : irap_pkg

`default_nettype wire

// ===== irap_port.sv
// Two-wire bus target giving access to a 7-bit addressed 16-bit register space.
// Assumes the register map answers reads combinationally and owns writability.
`default_nettype none

module irap_port #(
	parameter int PORTS = irap_pkg::NUM_PORTS
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_out,
	input wire logic [1:0] strap0_in,
	input wire logic [1:0] strap1_in,
	input wire logic ctx_mode_in,
	input wire logic [PORTS-1:0] dac_ports_in,
	input wire logic [PORTS-1:0] adc_ports_in,
	input wire logic [PORTS-1:0] used_map_in,
	input wire logic [PORTS-1:0] ro_map_in,
	output irap_pkg::irap_req_t req_out,
	input wire logic [15:0] rdata_in,
	input wire logic reg_used_in,
	input wire logic reg_writable_in
);
	import irap_pkg::*;

	// ============================================================
	// State
	typedef struct packed {
		logic [1:0] scl_s;
		logic [1:0] sda_s;
		logic scl_q;
		logic sda_q;
		logic strap_done;
		logic [2:0] addr_lo;
		irap_state_t st;
		irap_state_t after_ack;
		logic [3:0] bitn;
		logic [7:0] sh;
		logic hi_phase;
		logic [7:0] hi_byte;
		logic [6:0] ptr;
		logic is_read;
		logic drive;
		logic sda_o;
		logic [15:0] rbuf;
		logic [4:0] words;
		irap_req_t req;
	} irap_regs_t;

	irap_regs_t r;
	irap_regs_t next_r;

	logic scl_rise;
	logic scl_fall;
	logic start_c;
	logic stop_c;

	// ============================================================
	// Strap decode
	function automatic logic [1:0] strap_code(input logic [1:0] s);
		strap_code = s;
	endfunction : strap_code

	// Next higher configured port, wrapping to the lowest
	function automatic logic [6:0] ctx_next(input logic [6:0] p, input logic [6:0] base,
		input logic [PORTS-1:0] map);
		logic [6:0] res;
		logic found;
		logic [6:0] idx;
		res = p;
		found = 1'b0;
		idx = p - base;
		for (int i = 0; i < PORTS; i++) begin
			if (!found && map[i] && 7'(i) > idx) begin
				res = base + 7'(i);
				found = 1'b1;
			end
		end
		for (int i = 0; i < PORTS; i++) begin
			if (!found && map[i]) begin
				res = base + 7'(i);
				found = 1'b1;
			end
		end
		ctx_next = res;
	endfunction : ctx_next

	function automatic logic in_bank(input logic [6:0] p, input logic [6:0] base);
		in_bank = (p >= base) && (p < base + 7'(PORTS));
	endfunction : in_bank

	// ============================================================
	// Bus conditions
	always_comb begin
		scl_rise = r.scl_s[1] && !r.scl_q;
		scl_fall = !r.scl_s[1] && r.scl_q;
		start_c = r.scl_s[1] && r.scl_q && r.sda_q && !r.sda_s[1];
		stop_c = r.scl_s[1] && r.scl_q && !r.sda_q && r.sda_s[1];
	end

	// ============================================================
	// Protocol engine
	always_comb begin
		logic [6:0] adv;
		logic ctx;
		adv = 7'h00;
		ctx = 1'b0;
		next_r = r;
		next_r.scl_s = {r.scl_s[0], scl_in}; // R17
		next_r.sda_s = {r.sda_s[0], sda_in};
		next_r.scl_q = r.scl_s[1];
		next_r.sda_q = r.sda_s[1];
		next_r.req.wr = 1'b0;
		next_r.req.rd = 1'b0;

		if (!r.strap_done) begin // R16
			next_r.strap_done = 1'b1;
			next_r.addr_lo[2] = (strap1_in == STRAP_VDD) || (strap1_in == STRAP_SCL);
			next_r.addr_lo[1:0] = strap_code(strap0_in);
		end

		// Pointer advance after a complete word
		ctx = ctx_mode_in && (r.is_read ? in_bank(r.ptr, ADC_BASE) // R10
			: in_bank(r.ptr, DAC_BASE)); // R14
		if (ctx && r.is_read)
			adv = ctx_next(r.ptr, ADC_BASE, adc_ports_in); // R15
		else if (ctx)
			adv = ctx_next(r.ptr, DAC_BASE, dac_ports_in); // R12 R13
		else if (r.ptr == PTR_LAST)
			adv = r.ptr; // R4
		else
			adv = r.ptr + 7'h01; // R4

		if (start_c) begin
			next_r.st = IRAP_ADDR; // R5
			next_r.bitn = 4'h0;
			next_r.drive = 1'b0;
			next_r.hi_phase = 1'b1;
			next_r.words = 5'h00;
		end else if (stop_c) begin
			next_r.st = IRAP_IDLE; // R9
			next_r.drive = 1'b0;
		end else if (scl_rise) begin
			if (r.st inside {IRAP_ADDR, IRAP_PTR, IRAP_WDATA}) begin
				next_r.sh = {r.sh[6:0], r.sda_s[1]};
				next_r.bitn = r.bitn + 4'h1;
			end else if (r.st == IRAP_ACK_IN && r.sda_s[1]) begin
				next_r.st = IRAP_SKIP; // R9
			end
		end else if (scl_fall) begin
			unique case (r.st)
				IRAP_IDLE, IRAP_SKIP: next_r.drive = 1'b0;
				IRAP_ADDR: if (r.bitn == 4'h8) begin // R1
					next_r.bitn = 4'h0;
					if (r.sh[7:1] == {ADDR_FIXED, r.addr_lo}) begin
						next_r.is_read = r.sh[0];
						next_r.drive = 1'b1;
						next_r.sda_o = 1'b0;
						next_r.after_ack = r.sh[0] ? IRAP_RDATA : IRAP_PTR;
						next_r.st = IRAP_ACK_OUT;
						next_r.req.rd = r.sh[0];
						next_r.req.addr = r.ptr;
					end else begin
						next_r.st = IRAP_SKIP;
					end
				end
				IRAP_PTR, IRAP_WDATA: if (r.bitn == 4'h8) begin
					next_r.bitn = 4'h0;
					next_r.drive = 1'b1;
					next_r.sda_o = 1'b0;
					next_r.st = IRAP_ACK_OUT;
					next_r.after_ack = IRAP_WDATA;
					if (r.st == IRAP_PTR) begin
						next_r.ptr = r.sh[6:0]; // R1
						next_r.hi_phase = 1'b1;
					end else if (r.hi_phase) begin
						next_r.hi_byte = r.sh;
						// Map answers for the word's own address by the low byte
						next_r.req.addr = r.ptr; // R6 R7
						next_r.hi_phase = 1'b0;
					end else begin
						next_r.hi_phase = 1'b1;
						next_r.req.wr = reg_used_in && reg_writable_in; // R2 R6 R7
						next_r.req.addr = r.ptr;
						next_r.req.wdata = {r.hi_byte, r.sh};
						next_r.ptr = adv; // R3 R8
						next_r.words = r.words + 5'h01;
					end
				end
				IRAP_ACK_OUT: begin
					next_r.drive = 1'b0;
					next_r.st = r.after_ack;
					if (r.after_ack == IRAP_RDATA) begin
						if (r.hi_phase) begin
							next_r.rbuf = reg_used_in ? rdata_in : 16'h0000; // R6
							next_r.drive = !(reg_used_in ? rdata_in[15] : 1'b0);
						end else begin
							next_r.drive = !r.rbuf[7];
						end
						next_r.sda_o = 1'b0;
						next_r.bitn = 4'h1;
					end
				end
				IRAP_RDATA: begin
					if (r.bitn == 4'h8) begin
						next_r.drive = 1'b0;
						next_r.st = IRAP_ACK_IN;
						next_r.bitn = 4'h0;
						if (!r.hi_phase) begin
							next_r.ptr = adv; // R3 R8
							next_r.words = r.words + 5'h01;
							next_r.req.rd = 1'b1;
							next_r.req.addr = adv;
						end
					end else begin
						next_r.drive = !(r.hi_phase ? r.rbuf[4'd15 - r.bitn]
							: r.rbuf[4'd7 - r.bitn]);
						next_r.bitn = r.bitn + 4'h1;
					end
				end
				IRAP_ACK_IN: begin
					next_r.hi_phase = !r.hi_phase;
					next_r.st = IRAP_RDATA;
					next_r.bitn = 4'h1;
					if (!r.hi_phase) begin
						next_r.rbuf = reg_used_in ? rdata_in : 16'h0000; // R6
						next_r.drive = !(reg_used_in ? rdata_in[15] : 1'b0);
					end else begin
						next_r.drive = !r.rbuf[7];
					end
				end
				default: next_r.st = IRAP_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			r <= '0;
			r.scl_s <= 2'h3;
			r.sda_s <= 2'h3;
			r.scl_q <= 1'b1;
			r.sda_q <= 1'b1;
			r.st <= IRAP_IDLE;
			r.after_ack <= IRAP_IDLE;
		end else begin
			r <= next_r;
		end
	end

	// Open drain: only ever pulls low
	assign sda_out = 1'b0;
	assign sda_oe_out = r.drive;
	assign req_out = r.req;

	// ============================================================
	// Checks
	a_write_word_last: assert property (@(posedge clk_in) disable iff (rst_in)
		r.req.wr |-> $past(r.st) == IRAP_WDATA && $past(r.hi_phase) == 1'b0) // R2
		else $error("write strobe before low byte");
	a_ptr_hold_last: assert property (@(posedge clk_in) disable iff (rst_in)
		(!ctx_mode_in && $past(r.ptr) == PTR_LAST && $changed(r.words))
		|-> r.ptr == PTR_LAST) // R4
		else $error("pointer left last address");
	a_ro_discard: assert property (@(posedge clk_in) disable iff (rst_in)
		(scl_fall && r.st == IRAP_WDATA && !reg_writable_in) |=> !r.req.wr) // R7
		else $error("write to read-only register");
	a_unused_discard: assert property (@(posedge clk_in) disable iff (rst_in)
		(scl_fall && r.st == IRAP_WDATA && !reg_used_in) |=> !r.req.wr) // R6
		else $error("write to unused address");
	a_ptr_step_one: assert property (@(posedge clk_in) disable iff (rst_in) // R4
		(!$past(ctx_mode_in) && $changed(r.words) && r.words != 5'h00
		&& $past(r.ptr) != PTR_LAST) |-> r.ptr == $past(r.ptr) + 7'h01)
		else $error("pointer did not step by one");
	a_nack_foreign: assert property (@(posedge clk_in) disable iff (rst_in) // R16
		(scl_fall && r.st == IRAP_ADDR && r.bitn == 4'h8
		&& r.sh[7:1] != {ADDR_FIXED, r.addr_lo}) |=> !r.drive && r.st == IRAP_SKIP)
		else $error("answered a foreign address");
	a_rd_unused_zero: assert property (@(posedge clk_in) disable iff (rst_in) // R6
		(scl_fall && r.st == IRAP_ACK_IN && !r.hi_phase && !reg_used_in)
		|=> r.rbuf == 16'h0000)
		else $error("unused register read not zero");

endmodule : irap_port

`default_nettype wire

// ===== irap_host.sv
// Bit-level two-wire bus controller model driving the port.
// Assumes SDA has a pull-up and SCL is ours alone.
`default_nettype none
module irap_host (
	input wire logic clk_in,
	input wire logic sda_oe_in,
	output logic scl_out,
	output logic sda_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic pull_low;
	// Released line floats to the pull-up level
	assign sda_out = !(pull_low || sda_oe_in);
	initial begin
		scl_out = 1'b1;
		pull_low = 1'b0;
	end
	task wt(input int n);
		repeat (n) @(posedge clk_in);
	endtask : wt
	// One bit, 800 ns; data moves only while SCL is low
	task bit_io(input logic b, output logic r);
		wt(1);
		pull_low <= !b;
		wt(3);
		scl_out <= 1'b1;
		wt(2);
		r = sda_out;
		wt(2);
		scl_out <= 1'b0;
	endtask : bit_io
	// Also a repeated start when SCL is low
	task start_c;
		wt(1);
		pull_low <= 1'b0;
		wt(3);
		scl_out <= 1'b1;
		wt(4);
		pull_low <= 1'b1;
		wt(4);
		scl_out <= 1'b0;
	endtask : start_c
	task stop_c;
		wt(1);
		pull_low <= 1'b1;
		wt(3);
		scl_out <= 1'b1;
		wt(4);
		pull_low <= 1'b0;
		wt(4);
	endtask : stop_c
	// MSB first; k is the ninth bit, high to release or to NACK
	task byte_io(input logic [7:0] d, input logic k, output logic [7:0] r, output logic a);
		for (int i = 7; i >= 0; i--) bit_io(d[i], r[i]);
		bit_io(k, a);
	endtask : byte_io
endmodule : irap_host
`default_nettype wire

// ===== tb_top.sv
// Self-checking bench of the register access port.
// Assumes irap_pkg and irap_host are compiled first.
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import irap_pkg::*;
	logic clk_in, rst_in, scl, sda, sda_drv, sda_oe, ctx, used, wrt;
	logic [1:0] s0, s1;
	logic [19:0] dac, adc;
	logic [15:0] rdata;
	irap_req_t req;
	int n_mismatch = 0, num_checks = 0, cyc = 0;
	logic [22:0] wq[$];
	logic [15:0] rq[$];
	localparam logic [6:0] TA = {ADDR_FIXED, 3'h1};
	initial begin
		clk_in = 1'b0;
		forever #50 clk_in = ~clk_in;
	end
	function automatic logic [15:0] f(input logic [6:0] a);
		return {a, 2'h2, ~a};
	endfunction : f
	// Map: 0x7e unused, 0x00 read-only
	always_comb begin
		used = req.addr !== 7'h7e;
		wrt = used && req.addr !== 7'h00;
		rdata = f(req.addr);
	end
	irap_port u_dut (.clk_in(clk_in), .rst_in(rst_in), .scl_in(scl), .sda_in(sda),
		.sda_out(sda_drv), .sda_oe_out(sda_oe), .strap0_in(s0), .strap1_in(s1),
		.ctx_mode_in(ctx), .dac_ports_in(dac), .adc_ports_in(adc), .used_map_in(20'h0),
		.ro_map_in(20'h0), .req_out(req), .rdata_in(rdata), .reg_used_in(used),
		.reg_writable_in(wrt));
	irap_host u_host (.clk_in(clk_in), .sda_oe_in(sda_oe), .scl_out(scl), .sda_out(sda));
	always @(posedge clk_in) begin
		if (req.wr === 1'b1) wq.push_back({req.addr, req.wdata});
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			end_sim();
		end
	end
	// ====
	// Helpers
	task chk(input string nm, input logic [22:0] s, input logic [22:0] e);
		num_checks++;
		if (s !== e) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	task end_sim;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : end_sim
	task open_tx(input logic rd, input logic [6:0] p);
		logic [7:0] r;
		logic a;
		u_host.start_c();
		u_host.byte_io({TA, 1'b0}, 1'b1, r, a);
		chk("ack addr", a, 0);
		u_host.byte_io({1'b0, p}, 1'b1, r, a);
		chk("ack ptr", a, 0);
		if (rd) begin
			u_host.start_c();
			u_host.byte_io({TA, 1'b1}, 1'b1, r, a);
			chk("ack raddr", a, 0);
		end
	endtask : open_tx
	task wr_words(input int n, input logic [15:0] d);
		logic [7:0] r;
		logic a;
		int sz;
		for (int i = 0; i < n; i++) begin
			sz = wq.size();
			u_host.byte_io(8'(d >> 8), 1'b1, r, a);
			chk("early wr", wq.size(), sz);
			u_host.byte_io(d[7:0], 1'b1, r, a);
			chk("ack data", a, 0);
			d++;
		end
		u_host.stop_c();
	endtask : wr_words
	task rd_words(input int n);
		logic [7:0] h, l;
		logic a;
		for (int i = 0; i < n; i++) begin
			u_host.byte_io(8'hff, 1'b0, h, a);
			u_host.byte_io(8'hff, i == n - 1, l, a);
			rq.push_back({h, l});
		end
		u_host.stop_c();
	endtask : rd_words
	task exp_w(input logic [6:0] a, input logic [15:0] d);
		if (wq.size() == 0) chk("wr none", 0, {a, d});
		else chk("wr", wq.pop_front(), {a, d});
	endtask : exp_w
	// ====
	// Scenarios
	task t_plain;
		open_tx(0, 7'h7e);
		wr_words(3, 16'hc000);
		exp_w(7'h7f, 16'hc001);
		exp_w(7'h7f, 16'hc002);
		open_tx(0, 7'h00);
		wr_words(1, 16'h5555);
		open_tx(0, 7'h10);
		wr_words(2, 16'h0aff);
		exp_w(7'h10, 16'h0aff);
		exp_w(7'h11, 16'h0b00);
		open_tx(1, 7'h7d);
		rd_words(3);
		chk("rd0", rq.pop_front(), f(7'h7d));
		chk("rd1", rq.pop_front(), 0);
		chk("rd2", rq.pop_front(), f(7'h7f));
		$display("plain done");
	endtask : t_plain
	task t_ctx;
		ctx <= 1'b1;
		open_tx(0, 7'h62);
		wr_words(4, 16'h0100);
		exp_w(7'h62, 16'h0100);
		exp_w(7'h65, 16'h0101) ;
		exp_w(7'h73, 16'h0102);
		exp_w(7'h62, 16'h0103);
		open_tx(1, 7'h47);
		rd_words(3);
		chk("crd0", rq.pop_front(), f(7'h47));
		chk("crd1", rq.pop_front(), f(7'h40));
		chk("crd2", rq.pop_front(), f(7'h47));
		open_tx(0, 7'h20);
		wr_words(2, 16'h0200);
		exp_w(7'h20, 16'h0200);
		exp_w(7'h21, 16'h0201);
		ctx <= 1'b0;
		$display("ctx done");
	endtask : t_ctx
	task t_addr;
		logic [7:0] r;
		logic a;
		u_host.start_c();
		u_host.byte_io({TA ^ 7'h1, 1'b0}, 1'b1, r, a);
		chk("nack addr", a, 1);
		u_host.stop_c();
		chk("no wr", wq.size(), 0);
		$display("addr done");
	endtask : t_addr
	initial begin
		rst_in = 1'b1;
		ctx = 1'b0;
		s0 = STRAP_SDA;
		s1 = STRAP_GND;
		dac = 20'h80024;
		adc = 20'h00081;
		repeat (16) @(posedge clk_in);
		rst_in <= 1'b0;
		repeat (4) @(posedge clk_in);
		t_plain();
		t_ctx();
		t_addr();
		end_sim();
	end
endmodule : tb_top
`default_nettype wire
